// ===== inc/bip_pkg.sv
// shared constants and types for the backplane interconnect port
`default_nettype none
package bip_pkg;
  localparam int unsigned DATA_W     = 32;           // shared data lines
  localparam int unsigned ARB_W      = 7;            // priority request lines
  localparam int unsigned CLK_DIV    = 3;            // bus cycle in core clocks
  localparam int unsigned CLK_LOW    = 1;            // core clocks low per bus cycle
  // address word fields
  localparam int unsigned MASK_HI    = 31;           // byte mask msb
  localparam int unsigned MASK_LO    = 28;           // byte mask lsb
  localparam int unsigned FUNC_HI    = 27;           // function code msb
  localparam int unsigned FUNC_LO    = 25;           // function code lsb
  localparam int unsigned ADDR_HI    = 24;           // longword address msb
  localparam int unsigned ADDR_LO    = 2;            // longword address lsb
  // fixed priority levels, line index is level minus one
  localparam int unsigned LVL_DIAG   = 6;            // remote_diagnosis_module
  localparam int unsigned LVL_IOA0   = 4;            // first io_bus_adapter
  localparam int unsigned LVL_MSA0   = 3;            // first mass_storage_adapter
  localparam int unsigned LVL_MSA1   = 2;            // further mass_storage_adapter
  localparam int unsigned LVL_MSA2   = 1;            // further mass_storage_adapter
  localparam int unsigned LVL_CPU    = 0;            // processor
  // transfer function codes
  typedef enum logic [2:0] {
    BIP_FN_READ      = 3'h0,
    BIP_FN_READ_LOCK = 3'h1,
    BIP_FN_READ_MOD  = 3'h2,
    BIP_FN_WRITE     = 3'h4,
    BIP_FN_WRITE_UNL = 3'h5,
    BIP_FN_WRITE_VEC = 3'h6
  } bip_func_type;
  // slave status codes
  typedef enum logic [1:0] {
    BIP_ST_NXM  = 2'h0,                                // nonexistent_memory_response
    BIP_ST_UCE  = 2'h1,                                // uncorrectable_error_status
    BIP_ST_CORR = 2'h2,
    BIP_ST_OK   = 2'h3
  } bip_status_type;
endpackage
`default_nettype wire

// ===== inc/bip_if.sv
// backplane wires joining the processor end and a subsystem end
`default_nettype none
interface bip_if;
  logic [31:0] data_p, data_s;       // data driven by each end
  logic        data_oe_n_p, data_oe_n_s;
  logic        busy_p, busy_s;       // data_bus_busy, active high drives
  logic        hold_p;               // hold, processor drives
  logic        wait_s;               // wait, subsystem drives
  logic [1:0]  status_s;             // status from slave
  logic        status_oe_n_s;
  logic [6:0]  arb_p, arb_s;         // priority request lines
  logic        bclk;                 // backplane_clock from processor
  // resolved wire levels
  logic [31:0] data;
  logic        busy;
  logic [6:0]  arb;
  logic [1:0]  status;
  assign data   = !data_oe_n_p ? data_p : (!data_oe_n_s ? data_s : '0);
  assign busy   = busy_p | busy_s;
  assign arb    = arb_p | arb_s;
  assign status = !status_oe_n_s ? status_s : '0;
  modport proc (output data_p, data_oe_n_p, busy_p, hold_p, arb_p, bclk,
                input data, busy, arb, status, wait_s);
  modport sub  (output data_s, data_oe_n_s, busy_s, wait_s, status_s, status_oe_n_s, arb_s,
                input data, busy, arb, hold_p, bclk);
endinterface
`default_nettype wire

// ===== src/bip_proc_end.sv
// processor end: bus clock, hold, lowest-priority master with status capture
// How it works
// - processor makes clock; all sample on it
// - bus cycle edge to edge, one-third low
// - address word then data longword on lines
// - low two address bits carry no meaning
// - master busy exactly the address cycle
// - slave stretches with busy until done
// - ready write slave stays quiet, data follows
// - hold stops anyone taking the lines
// - subsystem raises wait for interrupt
// - wait held until write vector done
// - one own priority line per subsystem
// - idle and no higher line: take next
// - higher line set: keep own asserted
// - fixed levels, diagnosis highest, processor lowest
// - slave returns two-bit status with data
// - function code in address bits 27:25
// - address bits 31:28 are byte mask
`default_nettype none
module bip_proc_end (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  bip_if.proc              bus,
  input  wire logic        hold_req_i,   // suspend bus activity
  input  wire logic        req_i,        // start a transfer
  input  wire logic [2:0]  func_i,
  input  wire logic [3:0]  mask_i,
  input  wire logic [22:0] lw_addr_i,    // longword address
  input  wire logic [31:0] wdata_i,
  output logic             busy_o,       // transfer in progress
  output logic             done_o,       // one-cycle completion pulse
  output logic [31:0]      rdata_o,
  output logic [1:0]       status_o,
  output logic             irq_o         // wait level seen on the bus
);
  typedef enum logic [2:0] {
    BIP_IDLE = 3'b000, BIP_ARB = 3'b001, BIP_ADDR = 3'b011,
    BIP_DATA = 3'b010, BIP_DONE = 3'b110
  } bip_state_type;

  // bus clock divider state
  logic [1:0] div_reg, div_next;
  logic       bclk_reg, bclk_next;
  logic       tick;                       // one pulse per bus cycle

  // divider: low for one of three core clocks
  always_comb begin
    div_next  = (div_reg == 2'(bip_pkg::CLK_DIV - 1)) ? 2'h0 : div_reg + 2'h1;
    bclk_next = (div_next >= 2'(bip_pkg::CLK_LOW));
  end
  assign tick = (div_reg == 2'(bip_pkg::CLK_DIV - 1));

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_reg  <= 2'h0;
      bclk_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      bclk_reg <= bclk_next;
    end
  end

  // registered transfer state
  bip_state_type state_reg, state_next;
  logic [31:0]   dout_reg, dout_next;
  logic          doe_n_reg, doe_n_next;
  logic          mbusy_reg, mbusy_next;
  logic          arbq_reg, arbq_next;
  logic          hold_reg, hold_next;
  logic          wr_reg, wr_next;
  logic [31:0]   wd_reg, wd_next;
  logic [31:0]   rd_reg, rd_next;
  logic [1:0]    st_reg, st_next;
  logic          done_reg, done_next;
  logic          irq_reg, irq_next;
  logic          higher;

  assign higher = |bus.arb[bip_pkg::ARB_W-1:bip_pkg::LVL_CPU+1];

  // transfer sequencer, advances once per bus cycle
  always_comb begin
    state_next = state_reg;
    dout_next  = dout_reg;
    doe_n_next = doe_n_reg;
    mbusy_next = 1'b0;
    arbq_next  = arbq_reg;
    hold_next  = hold_req_i;
    wr_next    = wr_reg;
    wd_next    = wd_reg;
    rd_next    = rd_reg;
    st_next    = st_reg;
    done_next  = 1'b0;
    irq_next   = bus.wait_s;
    if (tick) begin
      unique case (state_reg)
        BIP_IDLE: begin
          if (req_i) begin
            wr_next    = func_i[2];
            wd_next    = wdata_i;
            dout_next  = {mask_i, func_i, lw_addr_i, 2'h0};
            arbq_next  = 1'b1;
            state_next = BIP_ARB;
          end
        end
        BIP_ARB: begin
          if (!bus.busy && !hold_reg && !higher) begin
            doe_n_next = 1'b0;
            mbusy_next = 1'b1;
            state_next = BIP_ADDR;
          end
        end
        BIP_ADDR: begin
          // address cycle over; data phase or slave stretch follows
          if (wr_reg) dout_next = wd_reg;
          else        doe_n_next = 1'b1;
          state_next = BIP_DATA;
        end
        BIP_DATA: begin
          if (!bus.busy) begin
            rd_next    = bus.data;
            st_next    = bus.status;
            doe_n_next = 1'b1;
            arbq_next  = 1'b0;
            done_next  = 1'b1;
            state_next = BIP_DONE;
          end
        end
        BIP_DONE: state_next = BIP_IDLE;
        default:  state_next = BIP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= BIP_IDLE;
      dout_reg  <= 32'h0;
      doe_n_reg <= 1'b1;
      mbusy_reg <= 1'b0;
      arbq_reg  <= 1'b0;
      hold_reg  <= 1'b0;
      wr_reg    <= 1'b0;
      wd_reg    <= 32'h0;
      rd_reg    <= 32'h0;
      st_reg    <= 2'h0;
      done_reg  <= 1'b0;
      irq_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      dout_reg  <= dout_next;
      doe_n_reg <= doe_n_next;
      mbusy_reg <= tick ? mbusy_next : mbusy_reg;
      arbq_reg  <= arbq_next;
      hold_reg  <= hold_next;
      wr_reg    <= wr_next;
      wd_reg    <= wd_next;
      rd_reg    <= rd_next;
      st_reg    <= st_next;
      done_reg  <= done_next;
      irq_reg   <= irq_next;
    end
  end

  // bus drives and user outputs
  assign bus.bclk        = bclk_reg;
  assign bus.data_p      = dout_reg;
  assign bus.data_oe_n_p = doe_n_reg;
  assign bus.busy_p      = mbusy_reg;
  assign bus.hold_p      = hold_reg;
  assign bus.arb_p       = {6'h00, arbq_reg};
  assign busy_o          = arbq_reg;
  assign done_o          = done_reg;
  assign rdata_o         = rd_reg;
  assign status_o        = st_reg;
  assign irq_o           = irq_reg;
endmodule
`default_nettype wire

// ===== src/bip_sub_end.sv
// subsystem end: slave with stretchable busy, wait interrupt, own arb line held low
`default_nettype none
module bip_sub_end #(
  parameter int unsigned LEVEL = bip_pkg::LVL_IOA0,  // priority line index
  parameter int unsigned LAT   = 2                   // bus cycles slave needs
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  bip_if.sub               bus,
  input  wire logic        irq_req_i,   // pulse: ask for service
  input  wire logic        ready_i,     // 1: accept writes at once
  output logic             wr_o,        // one-cycle write strobe
  output logic [22:0]      wr_addr_o,
  output logic [3:0]       wr_mask_o,
  output logic [31:0]      wr_data_o,
  output logic             vec_o        // write vector received pulse
);
  typedef enum logic [1:0] {
    BIS_IDLE = 2'b00, BIS_WAIT = 2'b01, BIS_DATA = 2'b11
  } bis_state_type;

  // bus clock edge detect; both ends run on clk_i, so the lines need no synchroniser
  // and the address word is still on the lines when the slave looks at it
  logic       clk_prev_reg;
  logic       rise;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= bus.bclk;
    end
  end
  assign rise = bus.bclk & ~clk_prev_reg;

  logic [31:0]   mem [4];                                // tiny backing store
  bis_state_type state_reg, state_next;
  logic [31:0]   addr_reg, addr_next;
  logic [7:0]    cnt_reg, cnt_next;
  logic          sbusy_reg, sbusy_next;
  logic          soe_n_reg, soe_n_next;
  logic          stoe_n_reg, stoe_n_next;                // status drive, low active
  logic [31:0]   sout_reg, sout_next;
  logic          wait_reg, wait_next;
  logic          wr_reg, wr_next;
  logic [31:0]   wd_reg, wd_next;
  logic          vec_reg, vec_next;
  logic          arb_reg;
  logic [2:0]    fn;
  assign fn = addr_reg[bip_pkg::FUNC_HI:bip_pkg::FUNC_LO];

  always_comb begin
    state_next = state_reg;
    addr_next  = addr_reg;
    cnt_next   = cnt_reg;
    sbusy_next = sbusy_reg;
    soe_n_next = soe_n_reg;
    stoe_n_next = stoe_n_reg;
    sout_next  = sout_reg;
    wait_next  = wait_reg | irq_req_i;
    wr_next    = 1'b0;
    wd_next    = wd_reg;
    vec_next   = 1'b0;
    if (rise) begin
      soe_n_next = 1'b1;
      stoe_n_next = 1'b1;
      unique case (state_reg)
        BIS_IDLE: if (bus.busy && bus.data_oe_n_s) begin                   // address cycle
          addr_next  = bus.data;
          cnt_next   = 8'(LAT);
          sbusy_next = !(bus.data[bip_pkg::FUNC_HI] && ready_i);
          state_next = BIS_WAIT;
        end
        BIS_WAIT: begin
          if (cnt_reg > 8'h1 && sbusy_reg) cnt_next = cnt_reg - 8'h1;
          else begin
            sbusy_next  = 1'b0;
            stoe_n_next = 1'b0;
            if (!fn[2]) begin
              soe_n_next = 1'b0;                                           // read data phase
              sout_next  = mem[addr_reg[3:2]];
            end else begin
              // write data stands now; the master may drop it at its next tick
              wd_next = bus.data;
              wr_next = 1'b1;
              if (fn == bip_pkg::BIP_FN_WRITE_VEC) begin
                vec_next  = 1'b1;
                wait_next = irq_req_i;
              end
            end
            state_next = BIS_DATA;
          end
        end
        // drives were released at the top of this bus cycle
        BIS_DATA: state_next = BIS_IDLE;
        default: state_next = BIS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= BIS_IDLE; addr_reg <= 32'h0; cnt_reg <= 8'h0;
      sbusy_reg <= 1'b0; soe_n_reg <= 1'b1; sout_reg <= 32'h0;
      wait_reg <= 1'b0; wr_reg <= 1'b0; wd_reg <= 32'h0; vec_reg <= 1'b0;
      arb_reg <= 1'b0; stoe_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next; addr_reg <= addr_next; cnt_reg <= cnt_next;
      sbusy_reg <= sbusy_next; soe_n_reg <= soe_n_next; sout_reg <= sout_next;
      wait_reg <= wait_next; wr_reg <= wr_next; wd_reg <= wd_next; vec_reg <= vec_next;
      arb_reg <= 1'b0;                                                     // slave-only
      stoe_n_reg <= stoe_n_next;
    end
  end

  // byte-masked store of written data
  always_ff @(posedge clk_i) begin
    for (int b = 0; b < 4; b++) begin
      if (wr_reg && addr_reg[bip_pkg::MASK_LO + b]) begin
        mem[addr_reg[3:2]][8*b +: 8] <= wd_reg[8*b +: 8];
      end
    end
  end

  assign bus.data_s        = sout_reg;
  assign bus.data_oe_n_s   = soe_n_reg;
  assign bus.busy_s        = sbusy_reg;
  assign bus.wait_s        = wait_reg;
  assign bus.status_s      = bip_pkg::BIP_ST_OK;
  assign bus.status_oe_n_s = stoe_n_reg;
  assign bus.arb_s         = 7'(arb_reg) << LEVEL;
  assign wr_o              = wr_reg;
  assign wr_addr_o         = addr_reg[bip_pkg::ADDR_HI:bip_pkg::ADDR_LO];
  assign wr_mask_o         = addr_reg[bip_pkg::MASK_HI:bip_pkg::MASK_LO];
  assign wr_data_o         = wd_reg;
  assign vec_o             = vec_reg;
endmodule
`default_nettype wire

// ===== test/bip_monitor.sv
// wire-level assertions between the processor end and the subsystem end
`default_nettype none
module bip_monitor (
  input wire logic       clk_i,
  input wire logic       arst_n_i,
  input wire logic       bclk,
  input wire logic       busy_p,
  input wire logic       busy_s,
  input wire logic       hold_p,
  input wire logic       data_oe_n_p,
  input wire logic       data_oe_n_s,
  input wire logic [6:0] arb_p
);
  // one domain: all checks off while reset is low
  default clocking mon_cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // bus clock is high two core clocks, then low one
  a_bclk_high_two: assert property ($rose(bclk) |-> bclk ##1 bclk ##1 !bclk)
    else $error("bus clock high phase not two clocks");
  a_bclk_low_one: assert property ($fell(bclk) |=> bclk)
    else $error("bus clock low phase not one clock");
  // master raises busy with the address word, for one bus cycle
  a_busy_with_addr: assert property ($fell(data_oe_n_p) |-> busy_p)
    else $error("address driven without master busy");
  a_busy_one_cycle: assert property ($rose(busy_p) |-> busy_p [*3] ##1 !busy_p)
    else $error("master busy not one bus cycle");
  // never two drivers on the data lines
  a_single_driver: assert property (!(!data_oe_n_p && !data_oe_n_s))
    else $error("both ends drive the data lines");
  // processor drives only while holding its own line alone
  a_own_line_only: assert property (!data_oe_n_p |-> arb_p == 7'h01)
    else $error("driving without own priority line");
  // lines and request dropped together after the data phase
  a_release_line: assert property ($rose(data_oe_n_p) && !$past(busy_p) |-> arb_p == 7'h00)
    else $error("priority line kept after release");
  // no take-over while hold is up
  a_hold_no_grab: assert property ($fell(data_oe_n_p) |-> !hold_p)
    else $error("data lines taken during hold");
  // take-over only after requesting on an idle bus
  a_idle_grant: assert property ($fell(data_oe_n_p) |-> $past(arb_p[0]) && !$past(busy_s))
    else $error("data lines taken without request on idle bus");
endmodule
`default_nettype wire

// ===== test/backplane_interconnect_port_bench.sv
// self-checking bench joining the processor end and a subsystem end
`default_nettype none
module backplane_interconnect_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // one table row: request fields and the read data they should return
  typedef struct packed {
    bip_pkg::bip_func_type func;
    logic [3:0]            mask;
    logic [22:0]           addr;
    logic [31:0]           wdata;
    logic                  ready;
    logic [31:0]           exp;
  } bip_row_type;
  logic        clk_i, arst_n_i, hold_req_i, req_i, irq_req_i, ready_i;
  logic [2:0]  func_i;
  logic [3:0]  mask_i;
  logic [22:0] lw_addr_i;
  logic [31:0] wdata_i, rdata_o, wr_data_o;
  logic        busy_o, done_o, irq_o, wr_o, vec_o;
  logic [1:0]  status_o;
  logic [22:0] wr_addr_o;
  logic [3:0]  wr_mask_o;
  int          bad_count, compares, busy_s_cnt;
  logic        seen_wr, seen_vec, grabbed;
  logic [31:0] addr_word, got_data;
  logic [22:0] got_addr;
  logic [3:0]  got_mask;
  // writes fill the store, masked writes merge, reads return the merge
  bip_row_type rows [10] = '{
    '{bip_pkg::BIP_FN_WRITE, 4'hF, 23'h0, 32'h11223344, 1'h1, 32'h0},
    '{bip_pkg::BIP_FN_WRITE, 4'hF, 23'h1, 32'h55667788, 1'h0, 32'h0},
    '{bip_pkg::BIP_FN_WRITE_UNL, 4'hF, 23'h2, 32'h99AABBCC, 1'h1, 32'h0},
    '{bip_pkg::BIP_FN_WRITE, 4'hF, 23'h7, 32'hDDEEFF00, 1'h0, 32'h0},
    '{bip_pkg::BIP_FN_READ, 4'hF, 23'h0, 32'h0, 1'h1, 32'h11223344},
    '{bip_pkg::BIP_FN_READ_LOCK, 4'hF, 23'h1, 32'h0, 1'h0, 32'h55667788},
    '{bip_pkg::BIP_FN_WRITE, 4'h5, 23'h2, 32'hA5A5A5A5, 1'h1, 32'h0},
    '{bip_pkg::BIP_FN_READ_MOD, 4'hF, 23'h2, 32'h0, 1'h1, 32'h99A5BBA5},
    '{bip_pkg::BIP_FN_WRITE, 4'hA, 23'h3, 32'h5A5A5A5A, 1'h0, 32'h0},
    '{bip_pkg::BIP_FN_READ, 4'hF, 23'h7, 32'h0, 1'h1, 32'h5AEE5A00}};
  bip_if bip_if_inst ();
  bip_proc_end bip_proc_end_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus(bip_if_inst),
    .hold_req_i(hold_req_i), .req_i(req_i), .func_i(func_i), .mask_i(mask_i),
    .lw_addr_i(lw_addr_i), .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o),
    .rdata_o(rdata_o), .status_o(status_o), .irq_o(irq_o));
  bip_sub_end bip_sub_end_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus(bip_if_inst),
    .irq_req_i(irq_req_i), .ready_i(ready_i), .wr_o(wr_o), .wr_addr_o(wr_addr_o),
    .wr_mask_o(wr_mask_o), .wr_data_o(wr_data_o), .vec_o(vec_o));
  bip_monitor bip_monitor_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .bclk(bip_if_inst.bclk),
    .busy_p(bip_if_inst.busy_p), .busy_s(bip_if_inst.busy_s), .hold_p(bip_if_inst.hold_p),
    .data_oe_n_p(bip_if_inst.data_oe_n_p), .data_oe_n_s(bip_if_inst.data_oe_n_s),
    .arb_p(bip_if_inst.arb_p));
  // 250 MHz core clock
  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end
  // compare and count, report a mismatch at once
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // print counts and verdict, then stop
  task automatic wrap_up();
    $display("counts: compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one whole transfer with wire and port checks
  task automatic xfer(input bip_row_type r);
    int  n;
    logic drop, is_wr;
    n = 0;
    drop = 1'h0;
    is_wr = r.func[2];
    {seen_wr, seen_vec, busy_s_cnt, addr_word} = '0;
    @(posedge clk_i);
    func_i <= r.func;
    mask_i <= r.mask;
    lw_addr_i <= r.addr;
    wdata_i <= r.wdata;
    ready_i <= r.ready;
    req_i <= 1'h1;
    // run until done, then ten more cycles; done_o must be low again the next cycle
    while (n < 310) begin
      @(posedge clk_i);
      if (drop) req_i <= 1'h0;
      @(negedge clk_i);
      if (busy_o === 1'h1) drop = 1'h1;
      if (bip_if_inst.busy_s === 1'h1) busy_s_cnt++;
      if (bip_if_inst.data_oe_n_p === 1'h0 && bip_if_inst.busy_p === 1'h1)
        addr_word = bip_if_inst.data;
      if (wr_o === 1'h1) begin
        seen_wr = 1'h1;
        {got_addr, got_mask, got_data} = {wr_addr_o, wr_mask_o, wr_data_o};
      end
      if (vec_o === 1'h1) seen_vec = 1'h1;
      if (n >= 300) n++;
      else if (done_o === 1'h1) n = 300;
      else if (n == 299) n = 500;
      else n++;
      if (n == 301) check(done_o, 1'h0);
    end
    if (n == 500) begin
      check(32'h0, 32'h1);
      wrap_up();
    end
    check(addr_word, {r.mask, r.func, r.addr, 2'h0});
    check(status_o, bip_pkg::BIP_ST_OK);
    check(busy_s_cnt == 0, is_wr && r.ready);
    check({bip_if_inst.data_oe_n_p, bip_if_inst.arb_p}, 8'h80);
    if (!is_wr) check(rdata_o, r.exp);
    else if (r.func != bip_pkg::BIP_FN_WRITE_VEC) begin
      check(seen_wr, 1'h1);
      check({got_addr, got_mask, got_data}, {r.addr, r.mask, r.wdata});
    end
  endtask
  initial begin
    {arst_n_i, hold_req_i, req_i, irq_req_i, ready_i, func_i, mask_i} = '0;
    {lw_addr_i, wdata_i, bad_count, compares} = '0;
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    foreach (rows[i]) xfer(rows[i]);
    $display("table rows done");
    // hold blocks the take-over until it drops
    grabbed = 1'h0;
    @(posedge clk_i);
    hold_req_i <= 1'h1;
    fork
      xfer(rows[4]);
      begin
        repeat (30) begin
          @(negedge clk_i);
          if (bip_if_inst.data_oe_n_p === 1'h0) grabbed = 1'h1;
        end
        @(posedge clk_i);
        hold_req_i <= 1'h0;
      end
    join
    check(grabbed, 1'h0);
    $display("hold test done");
    // wait stays up through a plain write, drops after a write vector
    @(posedge clk_i);
    irq_req_i <= 1'h1;
    @(posedge clk_i);
    irq_req_i <= 1'h0;
    repeat (10) @(negedge clk_i);
    check({irq_o, bip_if_inst.wait_s}, 2'h3);
    xfer(rows[0]);
    check({irq_o, bip_if_inst.wait_s}, 2'h3);
    xfer('{bip_pkg::BIP_FN_WRITE_VEC, 4'hF, 23'h1, 32'h000000C4, 1'h1, 32'h0});
    check(seen_vec, 1'h1);
    repeat (10) @(negedge clk_i);
    check({irq_o, bip_if_inst.wait_s}, 2'h0);
    $display("wait test done");
    // reset in mid transfer clears the processor end drives and outputs
    @(posedge clk_i);
    req_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'h0;
    req_i <= 1'h0;
    @(negedge clk_i);
    check({busy_o, done_o, bip_if_inst.data_oe_n_p, bip_if_inst.bclk}, 4'h2);
    check(bip_if_inst.arb_p, 7'h00);
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    xfer(rows[0]);
    xfer(rows[4]);
    $display("reset test done");
    wrap_up();
  end
endmodule
`default_nettype wire
